// ===== core/crr_decoder.sv
// Purpose: call/return/soft-reset execution with APB register view
// Assumes: instr valid from the fetch path at Q1, same clock
// Notes:   four clock-enabled ticks make one instruction cycle
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "crr_defs.svh"
module crr_decoder import crr_pkg::*; #(
  parameter int STACK_DEPTH = 32,
  parameter int SPW         = 5
) (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire logic [15:0]        instr,
  input  wire logic               instr_valid,
  input  wire logic [11:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [`CRR_PCW-1:0]     prog_counter,
  output crr_regs_type            live_regs,
  output logic                    high_priority_global_int_enable,
  output logic                    low_priority_global_int_enable,
  output logic                    fetch_flush,
  output logic                    soft_reset,
  output logic [1:0]              q_phase
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [1:0]          q_r;
  crr_state_type       state_r;
  logic [15:0]         ir_r;
  logic                ir_vld_r;
  logic [`CRR_PCW-1:0] pc_r;
  logic [SPW-1:0]      sp_r;
  crr_regs_type        live_r;
  crr_regs_type        shadow_r;
  logic                hi_en_r;
  logic                lo_en_r;
  logic                losel_r;
  logic                soft_rst_r;
  logic                flush_r;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;
  logic [`CRR_PCW-1:0] stack_top;

  // soft reset clears the same state as the external reset
  wire rst_int = sys_rst | soft_rst_r; // [RULE_05]

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire is_call   = ir_r[15:11] == `CRR_CALL_TOP; // [RULE_01]
  wire is_reset  = ir_r == `CRR_RESET_OPC; // [RULE_06]
  wire is_iret   = ir_r[15:1] == `CRR_IRET_TOP; // [RULE_07]
  wire is_return = ir_r[15:1] == `CRR_RETURN_TOP; // [RULE_14]
  wire is_litret = ir_r[15:8] == `CRR_LITRET_TOP; // [RULE_11]
  wire s_bit     = ir_r[0];

  crr_op_type op;
  assign op = !ir_vld_r  ? CRR_OP_OTHER  :
              is_call   ? CRR_OP_CALL   :
              is_reset  ? CRR_OP_RESET  :
              is_iret   ? CRR_OP_IRET   :
              is_return ? CRR_OP_RETURN :
              is_litret ? CRR_OP_LITRET : CRR_OP_OTHER;

  wire exec   = state_r == CRR_EXEC;
  wire at_q1  = clk_en && q_r == `CRR_Q1;
  wire at_q2  = clk_en && q_r == `CRR_Q2;
  wire at_q4  = clk_en && q_r == `CRR_Q4;
  wire is_ret = op == CRR_OP_IRET || op == CRR_OP_RETURN;
  wire is_pop = is_ret || op == CRR_OP_LITRET;

  // offset n doubled and sign-extended to a byte offset
  wire [`CRR_PCW-1:0] off2 = {{(`CRR_PCW-12){ir_r[10]}}, ir_r[10:0], 1'b0};
  wire [`CRR_PCW-1:0] ret_addr = pc_r + `CRR_PC_STEP;
  wire [`CRR_PCW-1:0] call_tgt = ret_addr + off2; // [RULE_03]

  wire full    = sp_r == SPW'(STACK_DEPTH - 1);
  // overflow drops the push rather than corrupting entry 0
  wire push_en = exec && at_q2 && op == CRR_OP_CALL && !full; // [RULE_02]
  wire pop_en  = exec && at_q4 && is_pop;
  wire start_reset = exec && at_q2 && op == CRR_OP_RESET; // [RULE_06]
  wire [SPW-1:0] sp_up = sp_r + `CRR_SP_ONE;
  wire [SPW-1:0] sp_dn = sp_r - `CRR_SP_ONE;
  wire sp_empty = sp_r == `CRR_SP_EMPTY;
  wire [`CRR_PCW-1:0] pop_pc = sp_empty ? `CRR_PC_RST : stack_top;

  crr_stack_mem #(
    .DW    (`CRR_PCW),
    .DEPTH (STACK_DEPTH),
    .AW    (SPW)
  ) u_stack (
    .sys_clk (sys_clk),
    .clk_en  (clk_en),
    .wr_en   (push_en),
    .wr_addr (sp_up),
    .wr_data (ret_addr),
    .rd_addr (sp_r),
    .rd_data (stack_top)
  );

  // ------------------------------------------------------------
  // next-state selection
  // ------------------------------------------------------------
  logic [`CRR_PCW-1:0] pc_nxt;
  crr_regs_type        live_nxt;
  logic [SPW-1:0]      sp_nxt;
  crr_state_type       state_nxt;

  always_comb begin
    pc_nxt    = pc_r;
    live_nxt  = live_r;
    sp_nxt    = sp_r;
    state_nxt = state_r;
    if (push_en) begin
      sp_nxt = sp_up; // [RULE_02]
    end
    if (at_q4) begin
      unique case (state_r)
        CRR_NOP2: begin
          state_nxt = CRR_EXEC; // [RULE_04]
        end
        CRR_EXEC: begin
          if (op == CRR_OP_CALL) begin
            pc_nxt    = call_tgt; // [RULE_03]
            state_nxt = CRR_NOP2; // [RULE_04]
          end else if (is_pop) begin
            // PC reloads but no PC latch register does; latch registers live elsewhere
            pc_nxt    = pop_pc; // [RULE_07] [RULE_10] [RULE_13] [RULE_14]
            sp_nxt    = sp_empty ? sp_r : sp_dn; // [RULE_15]
            state_nxt = CRR_NOP2; // [RULE_12]
            if (is_ret && s_bit) begin
              live_nxt = shadow_r; // [RULE_09]
            end
            if (op == CRR_OP_LITRET) begin
              live_nxt.working = ir_r[7:0]; // [RULE_12]
            end
          end else if (ir_vld_r) begin
            pc_nxt = ret_addr;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  wire a_ctrl = paddr == `CRR_A_CTRL;
  wire a_stat = paddr == `CRR_A_STAT;
  wire a_pc   = paddr == `CRR_A_PC;
  wire a_live = paddr == `CRR_A_LIVE;
  wire a_shad = paddr == `CRR_A_SHAD;
  wire mapped = a_ctrl | a_stat | a_pc | a_live | a_shad;
  wire access = psel && penable && !pready_r;
  // write commits on the edge that completes the transfer
  wire wr_done = psel && penable && pready_r && pwrite;
  wire wr_stat = wr_done && a_stat;

  logic [31:0] stat_word;
  logic [31:0] rd_word;
  assign stat_word = {19'h00000, sp_r, 5'h00, state_r, lo_en_r, hi_en_r};
  assign rd_word = a_ctrl ? {31'h00000000, losel_r} :
                   a_stat ? stat_word :
                   a_pc   ? {11'h000, pc_r} :
                   a_live ? {12'h000, live_r} :
                   a_shad ? {12'h000, shadow_r} : 32'h00000000;

  // interrupt return picks the priority level set in ctrl
  wire set_hi_en = pop_en && op == CRR_OP_IRET && !losel_r; // [RULE_08]
  wire set_lo_en = pop_en && op == CRR_OP_IRET && losel_r; // [RULE_08]

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      q_r      <= `CRR_Q1;
      state_r  <= CRR_EXEC;
      ir_r     <= 16'h0000;
      ir_vld_r <= 1'b0;
      pc_r     <= `CRR_PC_RST;
      sp_r     <= `CRR_SP_EMPTY;
      live_r   <= `CRR_REGS_RST;
      flush_r  <= 1'b0;
    end else if (clk_en) begin
      q_r     <= q_r + 2'h1;
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      sp_r    <= sp_nxt;
      live_r  <= live_nxt;
      flush_r <= state_nxt == CRR_NOP2; // [RULE_04]
      if (at_q1) begin
        ir_r     <= instr;
        ir_vld_r <= instr_valid && exec;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      hi_en_r  <= 1'b0;
      lo_en_r  <= 1'b0;
      losel_r  <= 1'b0;
      shadow_r <= `CRR_REGS_RST;
    end else if (clk_en) begin
      // hardware set wins over a software clear in the same cycle
      hi_en_r <= set_hi_en | (wr_stat ? pwdata[`CRR_STAT_HI_EN] : hi_en_r);
      lo_en_r <= set_lo_en | (wr_stat ? pwdata[`CRR_STAT_LO_EN] : lo_en_r);
      if (wr_done && a_ctrl) begin
        losel_r <= pwdata[`CRR_CTRL_LOSEL];
      end
      if (wr_done && a_shad) begin
        shadow_r <= pwdata[19:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else if (clk_en) begin
      pready_r  <= access;
      pslverr_r <= access && !mapped;
      prdata_r  <= (access && !pwrite) ? rd_word : 32'h00000000;
    end
  end

  // the soft reset pulse lasts one enabled tick; only the external reset, not rst_int, resets it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      soft_rst_r <= 1'b0;
    end else if (clk_en) begin
      soft_rst_r <= start_reset; // [RULE_05]
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign prog_counter = pc_r;
  assign live_regs    = live_r;
  assign fetch_flush  = flush_r;
  assign soft_reset   = soft_rst_r;
  assign q_phase      = q_r;
  assign high_priority_global_int_enable = hi_en_r;
  assign low_priority_global_int_enable  = lo_en_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_call_decode: assert property (@(posedge sys_clk) disable iff (rst_int) // [RULE_01]
    (ir_vld_r && ir_r[15:11] == `CRR_CALL_TOP) |-> op == CRR_OP_CALL)
    else $error("relative call not decoded");

  a_push_first: assert property (@(posedge sys_clk) disable iff (rst_int) // [RULE_02]
    (push_en) |=> (pc_r == $past(pc_r) && sp_r == $past(sp_up)))
    else $error("push did not precede pc change");

  a_call_target: assert property (@(posedge sys_clk) disable iff (rst_int) // [RULE_03]
    (exec && at_q4 && op == CRR_OP_CALL)
    |=> (pc_r == $past(pc_r) + `CRR_PC_STEP + $past(off2) && live_r == $past(live_r)))
    else $error("call target wrong");

  a_call_two_cyc: assert property (@(posedge sys_clk) disable iff (rst_int) // [RULE_04]
    (exec && at_q4 && op == CRR_OP_CALL && clk_en) |=> (fetch_flush && state_r == CRR_NOP2))
    else $error("call second cycle missing");

  a_soft_reset_clr: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_05]
    soft_rst_r |=> (pc_r == `CRR_PC_RST && sp_r == `CRR_SP_EMPTY && !hi_en_r && !lo_en_r))
    else $error("soft reset left state");

  a_reset_at_q2: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_06]
    $rose(soft_rst_r) |-> ($past(q_r) == `CRR_Q2 && $past(ir_r) == `CRR_RESET_OPC))
    else $error("soft reset started at wrong phase");

  a_iret_enable: assert property (@(posedge sys_clk) disable iff (rst_int) // [RULE_08]
    (pop_en && op == CRR_OP_IRET) |=> (hi_en_r || lo_en_r))
    else $error("interrupt enable not set");

  a_shadow_keep: assert property (@(posedge sys_clk) disable iff (rst_int) // [RULE_09]
    (pop_en && is_ret && !s_bit) |=> live_r == $past(live_r))
    else $error("live regs changed with s clear");

  a_literal_w: assert property (@(posedge sys_clk) disable iff (rst_int) // [RULE_12]
    (pop_en && op == CRR_OP_LITRET) |=> (live_r.working == $past(ir_r[7:0]) && flush_r))
    else $error("literal not written");

  a_pop_sp: assert property (@(posedge sys_clk) disable iff (rst_int) // [RULE_15]
    (pop_en && !sp_empty) |=> (sp_r == $past(sp_r) - `CRR_SP_ONE && pc_r == $past(stack_top)))
    else $error("pop did not lower pointer");
endmodule

// ===== core/crr_defs.svh
// Purpose: constants for the call/return/reset decoder
// Assumes: 16-bit instruction words, 21-bit byte program counter
// Notes:   included by every design file that needs a number
//
// Functional notes
// (RULE_01) relative call: top bits 11011, 11-bit offset
// (RULE_02) push next address before changing PC
// (RULE_03) call target is PC+2+2n, flags untouched
// (RULE_04) relative call takes two cycles, second idle
// (RULE_05) soft reset acts like master clear reset
// (RULE_06) opcode 00FF, one cycle, reset at Q2
// (RULE_07) return-from-interrupt pops stack into PC
// (RULE_08) interrupt return sets high-or-low enable at Q4
// (RULE_09) s bit restores working/status/bank shadows
// (RULE_10) returns leave PC latch registers alone
// (RULE_11) return-with-literal: 0000 1100 then literal
// (RULE_12) literal to working reg, pop, two cycles
// (RULE_13) literal return keeps pc_high_latch unchanged
// (RULE_14) plain return pops at Q4, two cycles
// (RULE_15) each pop moves stack pointer down one; code holds it at zero on an empty pop
`ifndef CRR_DEFS_SVH
`define CRR_DEFS_SVH

`define CRR_PCW        21
`define CRR_Q1         2'h0
`define CRR_Q2         2'h1
`define CRR_Q4         2'h3
`define CRR_CALL_TOP   5'h1B
`define CRR_RESET_OPC  16'h00FF
`define CRR_IRET_TOP   15'h0008
`define CRR_RETURN_TOP 15'h0009
`define CRR_LITRET_TOP 8'h0C
`define CRR_PC_STEP    21'h000002
`define CRR_PC_RST     21'h000000
`define CRR_REGS_RST   20'h00000
`define CRR_SP_EMPTY   5'h00
`define CRR_SP_ONE     5'h01

`define CRR_A_CTRL     12'h000
`define CRR_A_STAT     12'h004
`define CRR_A_PC       12'h008
`define CRR_A_LIVE     12'h00C
`define CRR_A_SHAD     12'h010
`define CRR_CTRL_LOSEL 0
`define CRR_STAT_HI_EN 0
`define CRR_STAT_LO_EN 1
`define CRR_STAT_BUSY  2
`define CRR_STAT_SP_LO 8

`endif

// ===== core/crr_pkg.sv
// Purpose: types shared by the decoder and its testbench
// Assumes: nothing beyond the defs header
// Notes:   regs layout matches the live/shadow register words
package crr_pkg;
  typedef enum logic [0:0] {
    CRR_EXEC = 1'b0,
    CRR_NOP2 = 1'b1
  } crr_state_type;

  typedef enum logic [2:0] {
    CRR_OP_OTHER  = 3'h0,
    CRR_OP_CALL   = 3'h1,
    CRR_OP_RESET  = 3'h2,
    CRR_OP_IRET   = 3'h3,
    CRR_OP_RETURN = 3'h4,
    CRR_OP_LITRET = 3'h5
  } crr_op_type;

  typedef struct packed {
    logic [3:0] bank_select_register;
    logic [7:0] status;
    logic [7:0] working;
  } crr_regs_type;
endpackage

// ===== core/crr_stack_mem.sv
// Purpose: return stack storage, registered read port
// Assumes: caller keeps the pointer; entry 0 is never written
// Notes:   contents survive reset, like a real return stack
`timescale 1ns/1ps
module crr_stack_mem #(
  parameter int DW    = 21,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          sys_clk,
  input  wire logic          clk_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ===== verif/crr_fetch_model.sv
// Purpose: fetch path stand-in that feeds instruction words
// Assumes: the decoder samples a word only at its Q1 tick
// Notes:   off Q1 the word churns with churn_r; instr_valid follows valid_in in every phase
`timescale 1ns/1ps
module crr_fetch_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  q_phase,
  input  wire logic [15:0] word_in,
  input  wire logic        valid_in,
  output logic      [15:0] instr,
  output logic             instr_valid
);
  logic [15:0] churn_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      churn_r <= 16'h5A3C;
    else
      churn_r <= churn_r + 16'h01F3;
  end

  assign instr       = (q_phase == 2'h0) ? word_in : (~word_in ^ churn_r);
  assign instr_valid = valid_in;
endmodule

// ===== verif/call_return_reset_decode_tb.sv
// Purpose: self-checking bench for the call/return/reset decoder
// Assumes: clk_en high except one freeze check; APB waits on pready
// Notes:   model keeps pc, return stack and registers in ints/queues
`timescale 1ns/1ps
`include "crr_defs.svh"
module call_return_reset_decode_tb import crr_pkg::*; ();
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              clk_en  = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [11:0]       paddr   = 12'h000;
  logic [31:0]       pwdata  = 32'h0;
  logic [15:0]       word_in = 16'h0;
  logic              valid_in = 1'b0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [20:0]       pc;
  crr_regs_type      live;
  logic              hi_en;
  logic              lo_en;
  logic              flush;
  logic              srst;
  logic [1:0]        q;
  logic [15:0]       instr;
  logic              instr_valid;
  int                m_pc;
  int                stk[$];
  logic [19:0]       m_live;
  logic [19:0]       m_shad;
  logic              m_gh;
  logic              m_gl;
  logic              m_lo;
  int                failures;
  int                checks_done;
  logic [31:0]       rd;
  logic              err;
  int                n;

  always #20 sys_clk = ~sys_clk;

  crr_decoder crr_decoder_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .instr(instr),
    .instr_valid(instr_valid), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_counter(pc),
    .live_regs(live), .high_priority_global_int_enable(hi_en), .low_priority_global_int_enable(lo_en),
    .fetch_flush(flush), .soft_reset(srst), .q_phase(q));
  crr_fetch_model crr_fetch_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .q_phase(q),
    .word_in(word_in), .valid_in(valid_in), .instr(instr), .instr_valid(instr_valid));

  // ----------------------------------------
  // compare and close
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // apb master, one transfer per call
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      failures++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmp_state();
    chk("pc", 32'(pc), m_pc);
    chk("live", 32'(live), 32'(m_live));
    chk("gie", {30'h0, lo_en, hi_en}, {30'h0, m_gl, m_gh});
    apb(1'b0, `CRR_A_STAT, 32'h0);
    chk("sp", 32'(rd[12:8]), stk.size());
  endtask

  // ----------------------------------------
  // one instruction through the fetch model
  // ----------------------------------------
  task automatic op(input logic [15:0] w);
    int i;
    int cyc;
    cyc = 2;
    if (w == `CRR_RESET_OPC) begin
      cyc = 1;
      m_pc = 0;
      m_live = '0;
      m_shad = '0;
      {m_gh, m_gl, m_lo} = 3'h0;
      stk.delete();
    end else if (w[15:11] == `CRR_CALL_TOP) begin
      // a full stack drops the push but the jump still happens
      if (stk.size() < 31) stk.push_back((m_pc + 2) & 32'h001FFFFF);
      m_pc = (m_pc + 2 + 2 * int'($signed(w[10:0]))) & 32'h001FFFFF;
    end else if (w[15:8] == `CRR_LITRET_TOP || w[15:1] == `CRR_IRET_TOP || w[15:1] == `CRR_RETURN_TOP) begin
      m_pc = (stk.size() > 0) ? stk.pop_back() : 0;
      if (w[15:8] == `CRR_LITRET_TOP) m_live[7:0] = w[7:0];
      else if (w[0]) m_live = m_shad;
      if (w[15:1] == `CRR_IRET_TOP && m_lo) m_gl = 1'b1;
      else if (w[15:1] == `CRR_IRET_TOP) m_gh = 1'b1;
    end else begin
      cyc = 1;
      m_pc = (m_pc + 2) & 32'h001FFFFF;
    end
    for (i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      if (q === 2'h3) break;
    end
    if (i == 8) begin
      failures++;
      test_done();
    end
    @(posedge sys_clk);
    word_in <= w;
    valid_in <= 1'b1;
    @(posedge sys_clk);
    valid_in <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("soft reset", 32'(srst), 32'(w == `CRR_RESET_OPC));
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("flush", 32'(flush), 32'(cyc == 2));
    if (cyc == 2) begin
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("flush end", 32'(flush), 32'h0);
    end
    cmp_state();
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk);
    failures++;
    test_done();
  end

  initial begin
    void'($urandom(32'h7E69));
    {m_pc, m_live, m_shad, m_gh, m_gl, m_lo} = '0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    clk_en <= 1'b0;
    @(negedge sys_clk);
    chk("q", 32'(q), 32'h0);
    // enable low must hold the phase counter q
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("q frozen", 32'(q), 32'h0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    cmp_state();
    $display("test reset values done");
    n = $urandom_range(2047);
    op({5'h1B, 11'h400});
    op({5'h1B, 11'h3FF});
    op({5'h1B, n[10:0]});
    op(16'h0012);
    op(16'h0012);
    op(16'h0012);
    $display("test call and return done");
    apb(1'b1, `CRR_A_SHAD, {12'h0, 20'($urandom)});
    m_shad = pwdata[19:0];
    apb(1'b0, `CRR_A_SHAD, 32'h0);
    chk("shadow", rd, 32'(m_shad));
    op(16'h0013);
    apb(1'b1, `CRR_A_CTRL, 32'h0);
    op({5'h1B, 11'h010});
    op(16'h0010);
    apb(1'b1, `CRR_A_CTRL, 32'h1);
    m_lo = 1'b1;
    op({5'h1B, 11'h7F0});
    op(16'h0011);
    $display("test shadow and interrupt return done");
    n = $urandom_range(255);
    op({5'h1B, 11'h020});
    op({8'h0C, n[7:0]});
    op({8'h0C, 8'hFF});
    op(16'h0000);
    $display("test literal return and empty pop done");
    for (int i = 0; i < 32; i++) op({5'h1B, 11'h001});
    op(16'h00FF);
    $display("test full stack and soft reset done");
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test unmapped access done");
    test_done();
  end
endmodule
